/* File: cet_pkg.sv */
// package: constants and types for the load-group execution timing block
package cet_pkg;
  // instruction classes of the load and exchange groups
  typedef enum logic [3:0] {
    CET_OP_EX_A_REG  = 4'h0,
    CET_OP_EX_A_MEM  = 4'h1,
    CET_OP_LD_A_REG  = 4'h2,
    CET_OP_LD_A_MEM  = 4'h3,
    CET_OP_ST_A_REG  = 4'h4,
    CET_OP_ST_A_MEM  = 4'h5,
    CET_OP_LD16_IMM  = 4'h6,
    CET_OP_LD16_MEM  = 4'h7,
    CET_OP_LEA_DIR   = 4'h8,
    CET_OP_LEA_IDX   = 4'h9,
    CET_OP_LEA_BIDX  = 4'hA,
    CET_OP_POP_REG   = 4'hB,
    CET_OP_POP_MEM   = 4'hC,
    CET_OP_PUSH_REG  = 4'hD,
    CET_OP_PUSH_MEM  = 4'hE,
    CET_OP_SWAP_BANK = 4'hF
  } cet_op_t;

  // decoded instruction handed from the decoder
  typedef struct packed {
    cet_op_t op;
    logic    flush;
  } cet_instr_t;

  // bus request to memory and i/o
  typedef struct packed {
    logic req;
    logic wr;
  } cet_bus_t;

  localparam logic [3:0] CET_CYC_SWAP  = 4'h2;
  localparam logic [3:0] CET_CYC_LD2   = 4'h2;
  localparam logic [3:0] CET_CYC_LD3   = 4'h3;
  localparam logic [3:0] CET_CYC_EX4   = 4'h4;
  localparam logic [3:0] CET_CYC_EX5   = 4'h5;
  localparam logic [3:0] CET_CYC_LEA5  = 4'h5;
  localparam logic [3:0] CET_CYC_LEA6  = 4'h6;
  localparam logic [3:0] CET_CYC_PUSH8 = 4'h8;
  localparam logic [3:0] CET_CYC_STK9  = 4'h9;

  // bus clock divide select
  localparam logic [1:0] CET_DIV_1     = 2'h0;
  localparam logic [1:0] CET_DIV_2     = 2'h1;
  localparam logic [1:0] CET_DIV_4     = 2'h2;
  localparam int         CET_CLK_MHZ   = 25;
  localparam logic [3:0] CET_WAIT_MAX  = 4'hF;
endpackage

/* File: cet_busclk.sv */
// bus clock enable divider and wait-state bus transaction sequencer
`timescale 1ns/10ps
module cet_busclk (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [1:0] div_sel,
  input  wire logic [3:0] wait_prog,
  input  wire logic       wait_in,
  input  wire logic       start,
  output logic            bus_tick,
  output logic            busy,
  output logic            done
);
  logic [1:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] wcnt_q, wcnt_d;
  typedef enum logic [1:0] {
    CET_BT_IDLE = 2'b00,
    CET_BT_T1   = 2'b01,
    CET_BT_T2   = 2'b10,
    CET_BT_T3   = 2'b11
  } cet_bt_state_t;

  cet_bt_state_t st_q, st_d;  // t2 also carries the wait states
  logic       tick_q, tick_d;
  logic       done_q, done_d;

  always_comb begin
    div_d  = div_q;
    ph_d   = ph_q;
    st_d   = st_q;
    wcnt_d = wcnt_q;
    done_d = 1'b0;
    // divider only changes between transactions, so a transfer never sees a mixed ratio
    if (st_q == CET_BT_IDLE) begin
      div_d = (div_sel == cet_pkg::CET_DIV_4) ? 2'h3 : (div_sel == cet_pkg::CET_DIV_2) ? 2'h1 : 2'h0;
    end
    ph_d   = (ph_q >= div_q) ? 2'h0 : ph_q + 2'h1;
    tick_d = (ph_d == 2'h0);
    if (start && st_q == CET_BT_IDLE) begin
      st_d   = CET_BT_T1;
      wcnt_d = wait_prog;
    end else if (tick_q) begin
      unique case (st_q)
        CET_BT_IDLE: st_d = CET_BT_IDLE;
        CET_BT_T1: st_d = CET_BT_T2;
        CET_BT_T2: begin
          // programmed waits first, then the external wait line extends further
          if (wcnt_q != 4'h0) begin
            wcnt_d = wcnt_q - 4'h1;
          end else if (!wait_in) begin
            st_d = CET_BT_T3;
          end
        end
        CET_BT_T3: begin
          st_d   = CET_BT_IDLE;
          done_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_q  <= 2'h0;
      ph_q   <= 2'h0;
      st_q   <= CET_BT_IDLE;
      wcnt_q <= 4'h0;
      tick_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      ph_q   <= ph_d;
      st_q   <= st_d;
      wcnt_q <= wcnt_d;
      tick_q <= tick_d;
      done_q <= done_d;
    end
  end

  assign bus_tick = tick_q;
  assign busy     = (st_q != CET_BT_IDLE);
  assign done     = done_q;

  a_wait_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_BT_T2 && tick_q && wcnt_q == 4'h0 && wait_in) |=> st_q == CET_BT_T2)
    else $error("wait input did not hold bus transaction");
  a_tick_div1: assert property (@(posedge clock) disable iff (sys_rst)
    (div_q == 2'h0 && $past(div_q) == 2'h0 && !$past(sys_rst)) |-> tick_q)
    else $error("bus tick missing at divide by one");
endmodule // cet_busclk

/* File: cet_exec.sv */
// execution stage timing for the load and exchange groups
// How it works
// - flush marks and interrupts discard pipeline contents
// - after flush, stall until next instruction decoded
// - bus clock is cpu clock over 1,2,4
// - wait input and programmed waits stretch transactions
// - time is fixed cycles plus bus transactions
// - exchange accumulator: 4 register, 5 plus read,write
// - load accumulator: 2 register, 3 plus read
// - store accumulator: 3 plus write, register 2
// - 16-bit load: immediate 2, memory 3 plus read
// - effective address: 2, 5, or 6 cycles
// - pop: 9 plus read, memory adds write
// - push: 8 plus write, memory 9 read,write
// - execution competes with prefetch for the bus
`timescale 1ns/10ps
module cet_exec (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire cet_pkg::cet_instr_t instr,
  input  wire logic               instr_valid,
  input  wire logic               irq_or_trap,
  input  wire logic               prefetch_req,
  input  wire logic [1:0]         div_sel,
  input  wire logic [3:0]         wait_prog,
  input  wire logic               wait_pin,
  output logic                    instr_ready,
  output logic                    pipe_flush,
  output cet_pkg::cet_bus_t       bus_out,
  output logic                    prefetch_grant,
  output logic                    exec_done
);
  typedef enum logic [2:0] {
    CET_ST_IDLE  = 3'b000,
    CET_ST_FIXED = 3'b001,
    CET_ST_RD    = 3'b010,
    CET_ST_WR    = 3'b011,
    CET_ST_REFIL = 3'b100
  } cet_state_t;

  typedef struct packed {
    logic [3:0] cyc;
    logic       rd;
    logic       wr;
  } cet_cost_t;

  // cycle count and bus needs of one instruction class
  function automatic cet_cost_t cost_of(input cet_pkg::cet_op_t op);
    cet_cost_t c;
    c = '{cyc: cet_pkg::CET_CYC_LD2, rd: 1'b0, wr: 1'b0};
    unique case (op)
      cet_pkg::CET_OP_EX_A_REG:  c = '{cet_pkg::CET_CYC_EX4, 1'b0, 1'b0};
      cet_pkg::CET_OP_EX_A_MEM:  c = '{cet_pkg::CET_CYC_EX5, 1'b1, 1'b1};
      cet_pkg::CET_OP_LD_A_REG:  c = '{cet_pkg::CET_CYC_LD2, 1'b0, 1'b0};
      cet_pkg::CET_OP_LD_A_MEM:  c = '{cet_pkg::CET_CYC_LD3, 1'b1, 1'b0};
      cet_pkg::CET_OP_ST_A_REG:  c = '{cet_pkg::CET_CYC_LD2, 1'b0, 1'b0};
      cet_pkg::CET_OP_ST_A_MEM:  c = '{cet_pkg::CET_CYC_LD3, 1'b0, 1'b1};
      cet_pkg::CET_OP_LD16_IMM:  c = '{cet_pkg::CET_CYC_LD2, 1'b0, 1'b0};
      cet_pkg::CET_OP_LD16_MEM:  c = '{cet_pkg::CET_CYC_LD3, 1'b1, 1'b0};
      cet_pkg::CET_OP_LEA_DIR:   c = '{cet_pkg::CET_CYC_LD2, 1'b0, 1'b0};
      cet_pkg::CET_OP_LEA_IDX:   c = '{cet_pkg::CET_CYC_LEA5, 1'b0, 1'b0};
      cet_pkg::CET_OP_LEA_BIDX:  c = '{cet_pkg::CET_CYC_LEA6, 1'b0, 1'b0};
      cet_pkg::CET_OP_POP_REG:   c = '{cet_pkg::CET_CYC_STK9, 1'b1, 1'b0};
      cet_pkg::CET_OP_POP_MEM:   c = '{cet_pkg::CET_CYC_STK9, 1'b1, 1'b1};
      cet_pkg::CET_OP_PUSH_REG:  c = '{cet_pkg::CET_CYC_PUSH8, 1'b0, 1'b1};
      cet_pkg::CET_OP_PUSH_MEM:  c = '{cet_pkg::CET_CYC_STK9, 1'b1, 1'b1};
      cet_pkg::CET_OP_SWAP_BANK: c = '{cet_pkg::CET_CYC_SWAP, 1'b0, 1'b0};
    endcase
    return c;
  endfunction

  // three-stage pin synchroniser for the external wait line
  logic [2:0] wsync_q, wsync_d;
  logic       wait_q, wait_d;

  cet_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic       need_rd_q, need_rd_d;
  logic       need_wr_q, need_wr_d;
  logic       flush_q, flush_d;
  logic       ready_q, ready_d;
  logic       done_q, done_d;
  logic       req_q, req_d;
  logic       wr_q, wr_d;
  logic       grant_q, grant_d;
  logic       flush_pend_q, flush_pend_d;
  logic       bt_start;
  logic       bt_busy;
  logic       bt_done;
  cet_cost_t  cost;

  cet_busclk cet_busclk_i (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .div_sel   (div_sel),
    .wait_prog (wait_prog),
    .wait_in   (wait_q),
    .start     (bt_start),
    .bus_tick  (),
    .busy      (bt_busy),
    .done      (bt_done)
  );

  always_comb begin
    wsync_d = {wsync_q[1:0], wait_pin};
    // a change counts only once stages two and three agree
    wait_d  = (wsync_q[2] == wsync_q[1]) ? wsync_q[2] : wait_q;
  end

  assign cost     = cost_of(instr.op);
  assign bt_start = (st_q == CET_ST_RD || st_q == CET_ST_WR) && !bt_busy && !bt_done;

  always_comb begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    need_rd_d    = need_rd_q;
    need_wr_d    = need_wr_q;
    flush_d      = 1'b0;
    ready_d      = 1'b0;
    done_d       = 1'b0;
    req_d        = req_q;
    wr_d         = wr_q;
    flush_pend_d = flush_pend_q;
    if (irq_or_trap) begin
      flush_d = 1'b1;
      st_d    = CET_ST_REFIL;
      req_d   = 1'b0;
    end else begin
      unique case (st_q)
        CET_ST_IDLE: begin
          if (instr_valid) begin
            // counting starts the cycle after the decoded instruction is taken, when instr_ready is high
            ready_d      = 1'b1;
            cnt_d        = cost.cyc - 4'h1;
            need_rd_d    = cost.rd;
            need_wr_d    = cost.wr;
            flush_pend_d = instr.flush;
            st_d         = CET_ST_FIXED;
          end
        end
        CET_ST_FIXED: begin
          if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
          end else if (need_rd_q) begin
            st_d  = CET_ST_RD;
            req_d = 1'b1;
            wr_d  = 1'b0;
          end else if (need_wr_q) begin
            st_d  = CET_ST_WR;
            req_d = 1'b1;
            wr_d  = 1'b1;
          end else begin
            done_d  = 1'b1;
            flush_d = flush_pend_q;
            st_d    = flush_pend_q ? CET_ST_REFIL : CET_ST_IDLE;
          end
        end
        CET_ST_RD: begin
          if (bt_done) begin
            need_rd_d = 1'b0;
            wr_d      = 1'b1;
            req_d     = need_wr_q;
            st_d      = need_wr_q ? CET_ST_WR : CET_ST_FIXED;
          end
        end
        CET_ST_WR: begin
          if (bt_done) begin
            need_wr_d = 1'b0;
            req_d     = 1'b0;
            st_d      = CET_ST_FIXED;
          end
        end
        CET_ST_REFIL: begin
          // refill time is outside the counted cycles
          req_d = 1'b0;
          if (instr_valid) begin
            st_d = CET_ST_IDLE;
          end
        end
        default: st_d = CET_ST_IDLE;
      endcase
    end
    // prefetch is shut out from the edge a transfer request is raised, not one cycle late
    grant_d      = prefetch_req && !req_d && !bt_busy && !bt_start && st_q != CET_ST_RD && st_q != CET_ST_WR;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wsync_q      <= 3'h0;
      wait_q       <= 1'b0;
      st_q         <= CET_ST_IDLE;
      cnt_q        <= 4'h0;
      need_rd_q    <= 1'b0;
      need_wr_q    <= 1'b0;
      flush_q      <= 1'b0;
      ready_q      <= 1'b0;
      done_q       <= 1'b0;
      req_q        <= 1'b0;
      wr_q         <= 1'b0;
      grant_q      <= 1'b0;
      flush_pend_q <= 1'b0;
    end else begin
      wsync_q      <= wsync_d;
      wait_q       <= wait_d;
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      need_rd_q    <= need_rd_d;
      need_wr_q    <= need_wr_d;
      flush_q      <= flush_d;
      ready_q      <= ready_d;
      done_q       <= done_d;
      req_q        <= req_d;
      wr_q         <= wr_d;
      grant_q      <= grant_d;
      flush_pend_q <= flush_pend_d;
    end
  end

  assign instr_ready    = ready_q;
  assign pipe_flush     = flush_q;
  assign bus_out        = '{req: req_q, wr: wr_q};
  assign prefetch_grant = grant_q;
  assign exec_done      = done_q;

  a_irq_flush: assert property (@(posedge clock) disable iff (sys_rst)
    irq_or_trap |=> pipe_flush && st_q == CET_ST_REFIL)
    else $error("interrupt did not flush pipeline");
  a_refill_stall: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_REFIL && !instr_valid && !irq_or_trap) |=> st_q == CET_ST_REFIL && !exec_done)
    else $error("execution left refill before decode");
  a_lea_base_six: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_LEA_BIDX && !irq_or_trap)
    ##1 !irq_or_trap [*6] |=> exec_done)
    else $error("base index address load not six cycles");
  a_ld_reg_two: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_LD_A_REG && !irq_or_trap)
    ##1 !irq_or_trap [*2] |-> !exec_done ##1 exec_done)
    else $error("register load to accumulator not two cycles");
  a_ex_reg_four: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_EX_A_REG && !irq_or_trap)
    ##1 !irq_or_trap [*4] |=> exec_done)
    else $error("register exchange not four cycles");
  a_read_first: assert property (@(posedge clock) disable iff (sys_rst)
    (bus_out.req && bus_out.wr && need_rd_q) |-> 1'b0)
    else $error("write issued before pending read");
  a_grant_excl: assert property (@(posedge clock) disable iff (sys_rst)
    prefetch_grant |-> $past(st_q) != CET_ST_RD && $past(st_q) != CET_ST_WR)
    else $error("prefetch granted during execution transfer");
  a_push_write: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_PUSH_REG && !irq_or_trap)
    ##1 !irq_or_trap [*8] |=> st_q == CET_ST_WR)
    else $error("push write not after eight cycles");
  a_pop_read: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_POP_REG && !irq_or_trap)
    ##1 !irq_or_trap [*8] |-> ##2 (st_q == CET_ST_RD || irq_or_trap || $past(irq_or_trap)))
    else $error("pop read not after nine cycles");
  a_store_mem: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_ST_A_MEM && !irq_or_trap)
    ##1 !irq_or_trap [*3] |=> st_q == CET_ST_WR && bus_out.wr)
    else $error("store write not after three cycles");
  a_ld16_imm: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q == CET_ST_IDLE && instr_valid && instr.op == cet_pkg::CET_OP_LD16_IMM && !irq_or_trap)
    ##1 !irq_or_trap [*2] |=> exec_done)
    else $error("16-bit immediate load not two cycles");
endmodule // cet_exec

/* File: cet_mem_model.sv */
// behavioural memory and i/o on the system bus, with wait-state insertion
`timescale 1ns/10ps
module cet_mem_model (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire cet_pkg::cet_bus_t bus,
  input  wire logic [7:0]        hold_cyc,
  output logic                   wait_pin,
  output logic [7:0]             n_rd,
  output logic [7:0]             n_wr,
  output logic [1:0]             hist
);
  logic       req_q;
  logic       wr_q;
  logic       start;
  logic [7:0] cnt_q;

  // request may stay up from read into write: a direction flip starts a new transfer
  assign start    = bus.req && (!req_q || bus.wr != wr_q);
  // wait held from the start of each transfer; released level is inactive
  assign wait_pin = bus.req && ((start ? 8'h00 : cnt_q) < hold_cyc);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_q <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 8'h00;
      n_rd  <= 8'h00;
      n_wr  <= 8'h00;
      hist  <= 2'h0;
    end else begin
      req_q <= bus.req;
      wr_q  <= bus.wr;
      cnt_q <= !bus.req ? 8'h00 : start ? 8'h01 : cnt_q + 8'h01;
      // log each transfer once, at its start, to see read before write
      if (start) begin
        hist <= {hist[0], bus.wr};
        if (bus.wr) begin
          n_wr <= n_wr + 8'h01;
        end else begin
          n_rd <= n_rd + 8'h01;
        end
      end
    end
  end
endmodule // cet_mem_model

/* File: cet_exec_test.sv */
// testbench for the load-group execution timing block
`timescale 1ns/10ps
module cet_exec_test;
  logic                clock;
  logic                sys_rst;
  cet_pkg::cet_instr_t instr;
  logic                instr_valid;
  logic                irq_or_trap;
  logic                prefetch_req;
  logic [1:0]          div_sel;
  logic [3:0]          wait_prog;
  logic                wait_pin;
  logic                instr_ready;
  logic                pipe_flush;
  cet_pkg::cet_bus_t   bus_out;
  logic                prefetch_grant;
  logic                exec_done;
  logic [7:0]          hold_cyc;
  logic [7:0]          n_rd;
  logic [7:0]          n_wr;
  logic [1:0]          hist;
  int                  err_count;
  int                  num_checks;
  int                  cycles;
  int                  c0;
  int                  c1;

  cet_exec cet_exec_i (
    .clock(clock), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
    .irq_or_trap(irq_or_trap), .prefetch_req(prefetch_req), .div_sel(div_sel),
    .wait_prog(wait_prog), .wait_pin(wait_pin), .instr_ready(instr_ready),
    .pipe_flush(pipe_flush), .bus_out(bus_out), .prefetch_grant(prefetch_grant),
    .exec_done(exec_done)
  );

  cet_mem_model cet_mem_model_i (
    .clock(clock), .sys_rst(sys_rst), .bus(bus_out), .hold_cyc(hold_cyc),
    .wait_pin(wait_pin), .n_rd(n_rd), .n_wr(n_wr), .hist(hist)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // hang guard: whole run needs well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  // execution transfers must not share the bus with prefetch
  always @(negedge clock) if (!sys_rst && bus_out.req === 1'b1) chk(prefetch_grant, 1'b0);

  // offsets counted from the cycle where instr_ready is seen
  task automatic run_op(input cet_pkg::cet_op_t o, input logic fl, input int n, input int rd, input int wr,
                        output int cyc);
    int t;
    int fr;
    int d;
    int k;
    logic [7:0] r0;
    logic [7:0] w0;
    @(negedge clock);
    d = (div_sel == cet_pkg::CET_DIV_2) ? 2 : (div_sel == cet_pkg::CET_DIV_4) ? 4 : 1;
    k = rd + wr;
    r0 = n_rd;
    w0 = n_wr;
    instr = '{op: o, flush: fl};
    instr_valid = 1'b1;
    t = 0;
    while (instr_ready !== 1'b1 && t < 50) begin
      @(negedge clock);
      t++;
    end
    instr_valid = 1'b0;
    cyc = 0;
    fr = -1;
    while (exec_done !== 1'b1 && cyc < 500) begin
      @(negedge clock);
      cyc++;
      if (bus_out.req === 1'b1 && fr < 0) fr = cyc;
    end
    chk(pipe_flush, fl);
    chk({24'h0, n_rd - r0}, rd);
    chk({24'h0, n_wr - w0}, wr);
    if (k == 0) chk(cyc, n);
    else begin
      chk(fr >= n - 1 && fr <= n - 1 + d, 1'b1);
      chk(cyc >= n - 1 + k * (2 + wait_prog) * d, 1'b1);
      chk(cyc <= n - 1 + k * ((5 + wait_prog) * d + hold_cyc + 6), 1'b1);
    end
    if (rd > 0 && wr > 0) chk(hist, 2'h1);
  endtask

  // every class back to back, fastest bus
  task automatic t_ops;
    int c;
    run_op(cet_pkg::CET_OP_EX_A_REG, 1'b0, 4, 0, 0, c);
    run_op(cet_pkg::CET_OP_EX_A_MEM, 1'b0, 5, 1, 1, c);
    run_op(cet_pkg::CET_OP_LD_A_REG, 1'b0, 2, 0, 0, c);
    run_op(cet_pkg::CET_OP_LD_A_MEM, 1'b0, 3, 1, 0, c);
    run_op(cet_pkg::CET_OP_ST_A_REG, 1'b0, 2, 0, 0, c);
    run_op(cet_pkg::CET_OP_ST_A_MEM, 1'b0, 3, 0, 1, c);
    run_op(cet_pkg::CET_OP_LD16_IMM, 1'b0, 2, 0, 0, c);
    run_op(cet_pkg::CET_OP_LD16_MEM, 1'b0, 3, 1, 0, c);
    run_op(cet_pkg::CET_OP_LEA_DIR, 1'b0, 2, 0, 0, c);
    run_op(cet_pkg::CET_OP_LEA_IDX, 1'b0, 5, 0, 0, c);
    run_op(cet_pkg::CET_OP_LEA_BIDX, 1'b0, 6, 0, 0, c);
    run_op(cet_pkg::CET_OP_POP_REG, 1'b0, 9, 1, 0, c);
    run_op(cet_pkg::CET_OP_POP_MEM, 1'b0, 9, 1, 1, c);
    run_op(cet_pkg::CET_OP_PUSH_REG, 1'b0, 8, 0, 1, c);
    run_op(cet_pkg::CET_OP_PUSH_MEM, 1'b0, 9, 1, 1, c);
    run_op(cet_pkg::CET_OP_SWAP_BANK, 1'b0, 2, 0, 0, c);
  endtask

  // divide ratios, programmed and external waits stretch transfers
  task automatic t_bus;
    run_op(cet_pkg::CET_OP_PUSH_MEM, 1'b0, 9, 1, 1, c0);
    div_sel = cet_pkg::CET_DIV_4;
    run_op(cet_pkg::CET_OP_PUSH_MEM, 1'b0, 9, 1, 1, c1);
    chk(c1 > c0 + 6, 1'b1);
    div_sel = cet_pkg::CET_DIV_2;
    run_op(cet_pkg::CET_OP_EX_A_MEM, 1'b0, 5, 1, 1, c1);
    div_sel = cet_pkg::CET_DIV_1;
    wait_prog = 4'h3;
    run_op(cet_pkg::CET_OP_PUSH_MEM, 1'b0, 9, 1, 1, c1);
    chk(c1 >= c0 + 6, 1'b1);
    // programmed waits give the three-flop wait synchroniser time to see the pin
    c0 = c1;
    hold_cyc = 8'h08;
    run_op(cet_pkg::CET_OP_PUSH_MEM, 1'b0, 9, 1, 1, c1);
    chk(c1 > c0 + 4, 1'b1);
    wait_prog = 4'h0;
    hold_cyc = 8'h00;
  endtask

  // flush-marked instruction, then refill must wait for the decoder
  task automatic t_flush;
    int i;
    run_op(cet_pkg::CET_OP_LD_A_REG, 1'b1, 2, 0, 0, c0);
    for (i = 0; i < 4; i++) begin
      @(negedge clock);
      chk(instr_ready, 1'b0);
    end
    run_op(cet_pkg::CET_OP_ST_A_MEM, 1'b0, 3, 0, 1, c0);
  endtask

  // interrupt held three cycles flushes each cycle and takes nothing
  task automatic t_irq;
    int i;
    int f;
    f = 0;
    @(negedge clock);
    irq_or_trap = 1'b1;
    for (i = 0; i < 5; i++) begin
      @(negedge clock);
      if (i == 2) irq_or_trap = 1'b0;
      if (pipe_flush === 1'b1) f++;
      chk(instr_ready, 1'b0);
    end
    chk(f, 3);
    run_op(cet_pkg::CET_OP_LEA_BIDX, 1'b0, 6, 0, 0, c0);
    @(negedge clock);
    @(negedge clock);
    chk(prefetch_grant, 1'b1);
  endtask

  initial begin
    sys_rst = 1'b1;
    instr = '{op: cet_pkg::CET_OP_LD_A_REG, flush: 1'b0};
    instr_valid = 1'b0;
    irq_or_trap = 1'b0;
    prefetch_req = 1'b1;
    div_sel = cet_pkg::CET_DIV_1;
    wait_prog = 4'h0;
    hold_cyc = 8'h00;
    repeat (20) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_ops();
    t_bus();
    t_flush();
    t_irq();
    conclude();
  end
endmodule // cet_exec_test
